// ===== bus_txn_pkg.sv
// Shared constants for the processor system-bus transaction controller.
`default_nettype none
package bus_txn_pkg;

  // Bus widths.
  localparam int AD_W = 64;
  localparam int CMD_W = 9;
  localparam int INT_W = 8;

  // Command bus layout: bit 8 tells an address cycle from a data cycle.
  localparam int CMD_DATA_BIT = 8;
  localparam int CMD_WRITE_BIT = 7;
  localparam int CMD_NULL_BIT = 6;
  localparam int CMD_SIZE_LSB = 0;
  localparam int CMD_SIZE_W = 3;

  // Data identifier layout in data cycles.
  localparam int ID_LAST_BIT = 7;
  localparam int ID_ERROR_BIT = 6;

  // Transfer sizes carried in the command.
  localparam logic [2:0] SIZE_PARTIAL_WORD = 3'h0;
  localparam logic [2:0] SIZE_WORD = 3'h1;
  localparam logic [2:0] SIZE_PARTIAL_DWORD = 3'h2;
  localparam logic [2:0] SIZE_DWORD = 3'h3;
  localparam logic [2:0] SIZE_BLOCK = 3'h4;

  // Doublewords in one block transfer.
  localparam logic [2:0] BLOCK_BEATS = 3'h4;

  // Ready inputs must be seen asserted this many cycles, then in one more cycle, before an issue.
  localparam logic [1:0] READY_HOLD_CYCLES = 2'h2;

  // Address at which an external write reaches the interrupt register.
  localparam logic [63:0] INT_REG_ADDR = 64'h0000_0000_0000_0000;

  // Reset value of the interrupt register.
  localparam logic [7:0] INT_REG_RESET = 8'h00;

  // Write styles.
  typedef enum logic [1:0] {
    WSTYLE_LEGACY = 2'h0,
    WSTYLE_REISSUE = 2'h1,
    WSTYLE_PIPELINED = 2'h2
  } write_style_t;

endpackage
`default_nettype wire

// ===== word_fifo_if.sv
// Valid/ready link between the write-data buffer and its two users.
`timescale 1ns/1ps
`default_nettype none
interface word_fifo_if #(
  parameter int WIDTH = 64
);
  logic inValid;
  logic inReady;
  logic [WIDTH-1:0] inData;
  logic outValid;
  logic outReady;
  logic [WIDTH-1:0] outData;

  modport buffer (
    input inValid, inData, outReady,
    output inReady, outValid, outData
  );

  modport user (
    output inValid, inData, outReady,
    input inReady, outValid, outData
  );
endinterface
`default_nettype wire

// ===== word_fifo.sv
// Parameterised word FIFO with registered fill-side ready.
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Both sides of the buffer.
  word_fifo_if.buffer port
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_COUNT = (PTR_W + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr_reg;
  logic [PTR_W-1:0] rdPtr_reg;
  logic [PTR_W:0] count_reg;
  logic [PTR_W:0] count_next;
  logic inReady_reg;
  logic push;
  logic pop;

  assign push = port.inValid && inReady_reg;
  assign pop = port.outValid && port.outReady;
  assign port.inReady = inReady_reg;
  assign port.outValid = (count_reg != '0);
  assign port.outData = mem[rdPtr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= port.inData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      inReady_reg <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_next;
      inReady_reg <= (count_next != FULL_COUNT);
    end
  end
endmodule // word_fifo
`default_nettype wire

// ===== bus_txn_ctrl.sv
// Processor-side transaction controller for the multiplexed system bus.
// How it works
// - Only one processor request outstanding at once.
// - Writes issue only with no read pending.
// - Reads and writes carry one of five sizes.
// - Read-ready gates reads, write-ready gates writes.
// - Reads may be split by external requests.
// - Read pending until final response word arrives.
// - Error identifier on response raises bus error.
// - Write finishes after final data word driven.
// - Legacy, reissue and pipelined write styles.
// - External requests: write one word, or null.
// - Null external request only returns mastership.
// - Handover pulses one cycle, three clock edges after agent request at the earliest.
// - Uncompelled handover during read needs cache miss when scEnable is set.
// - Mastership returns; no second external request meanwhile.
// - Idle processor picks grant or own request.
// - Grant while awaiting read-ready if request earlier.
// - Grant while awaiting write-ready if request earlier.
// - After voluntary handover, agent may precede response.
// - External writes reach only the interrupt register.
// - Responses accepted without any arbitration handshake.
// - Command top bit: 0 address, 1 data.
// - Valid signals qualify each side's bus cycles.
`timescale 1ns/1ps
`default_nettype none
module bus_txn_ctrl #(
  parameter int FIFO_DEPTH = 16,
  parameter int INT_WIDTH = bus_txn_pkg::INT_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Processor core request port.
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [2:0] reqSize,
  input wire logic [bus_txn_pkg::AD_W-1:0] reqAddr,
  // Processor core write data.
  input wire logic wdValid,
  output logic wdReady,
  input wire logic [bus_txn_pkg::AD_W-1:0] wdData,
  // Read response to the core.
  output logic rdValid,
  output logic [bus_txn_pkg::AD_W-1:0] rdData,
  output logic rdLast,
  output logic busError,
  output logic readPending,
  // Configuration and cache status.
  input wire logic [1:0] writeStyle,
  input wire logic scEnable,
  input wire logic scMiss,
  // Interrupt register written by the agent.
  output logic [INT_WIDTH-1:0] intReg,
  // System bus pins.
  input wire logic [bus_txn_pkg::AD_W-1:0] addr_data_bus_in,
  output logic [bus_txn_pkg::AD_W-1:0] addr_data_bus_out,
  output logic addr_data_bus_oe_n,
  input wire logic [bus_txn_pkg::CMD_W-1:0] cmd_bus_in,
  output logic [bus_txn_pkg::CMD_W-1:0] cmd_bus_out,
  output logic cmd_bus_oe_n,
  output logic cpu_drive_valid_n,
  input wire logic agent_drive_valid_n,
  input wire logic read_accept_n,
  input wire logic write_accept_n,
  input wire logic agent_bus_request_n,
  output logic handoverN
);
  localparam int AD_W = bus_txn_pkg::AD_W;
  localparam int CMD_W = bus_txn_pkg::CMD_W;
  localparam int SYNC_W = 4 + CMD_W + AD_W;
  // Active-low pins idle high after reset.
  localparam logic [SYNC_W-1:0] SYNC_RESET = {4'hf, {(CMD_W + AD_W){1'b0}}};

  typedef enum {
    ST_IDLE,
    ST_WAITRDY,
    ST_WDATA,
    ST_WGAP,
    ST_RWAIT,
    ST_SLAVE,
    ST_EXTDATA
  } state_t;

  function automatic logic [2:0] beatsFor(input logic [2:0] size);
    beatsFor = (size == bus_txn_pkg::SIZE_BLOCK) ? bus_txn_pkg::BLOCK_BEATS : 3'h1;
  endfunction

  function automatic state_t afterSlave(input state_t ret, input logic pending);
    afterSlave = (ret == ST_RWAIT && !pending) ? ST_IDLE : ret;
  endfunction

  // Pin synchroniser.
  logic [SYNC_W-1:0] syncA_reg;
  logic [SYNC_W-1:0] syncB_reg;
  logic rdAccept;
  logic wrAccept;
  logic agentReq;
  logic agentValid;
  logic [CMD_W-1:0] cmdIn;
  logic [AD_W-1:0] adIn;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_reg <= SYNC_RESET;
      syncB_reg <= SYNC_RESET;
    end else begin
      syncA_reg <= {read_accept_n, write_accept_n, agent_bus_request_n, agent_drive_valid_n,
                    cmd_bus_in, addr_data_bus_in};
      syncB_reg <= syncA_reg;
    end
  end

  assign rdAccept = !syncB_reg[SYNC_W-1];
  assign wrAccept = !syncB_reg[SYNC_W-2];
  assign agentReq = !syncB_reg[SYNC_W-3];
  assign agentValid = !syncB_reg[SYNC_W-4];
  assign cmdIn = syncB_reg[AD_W +: CMD_W];
  assign adIn = syncB_reg[AD_W-1:0];

  // Bus cycles seen from the agent.
  logic extAddrCycle;
  logic extDataCycle;
  assign extAddrCycle = agentValid && !cmdIn[bus_txn_pkg::CMD_DATA_BIT];
  assign extDataCycle = agentValid && cmdIn[bus_txn_pkg::CMD_DATA_BIT];

  // Write-data buffer.
  word_fifo_if #(.WIDTH(AD_W)) wbuf ();
  assign wbuf.inValid = wdValid;
  assign wbuf.inData = wdData;
  assign wdReady = wbuf.inReady;

  word_fifo #(
    .WIDTH(AD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wbuf (
    .clk(clk),
    .rst_n(rst_n),
    .port(wbuf)
  );

  // How long each ready input has been seen asserted.
  logic [1:0] rdHeld_reg;
  logic [1:0] wrHeld_reg;
  logic rdGo;
  logic wrGo;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdHeld_reg <= 2'h0;
      wrHeld_reg <= 2'h0;
    end else begin
      if (!rdAccept) begin
        rdHeld_reg <= 2'h0;
      end else if (rdHeld_reg != bus_txn_pkg::READY_HOLD_CYCLES) begin
        rdHeld_reg <= rdHeld_reg + 2'h1;
      end
      if (!wrAccept) begin
        wrHeld_reg <= 2'h0;
      end else if (wrHeld_reg != bus_txn_pkg::READY_HOLD_CYCLES) begin
        wrHeld_reg <= wrHeld_reg + 2'h1;
      end
    end
  end

  assign rdGo = rdAccept && (rdHeld_reg == bus_txn_pkg::READY_HOLD_CYCLES);
  assign wrGo = wrAccept && (wrHeld_reg == bus_txn_pkg::READY_HOLD_CYCLES);

  // Main sequencer and pin drivers.
  state_t state_reg;
  state_t ret_reg;
  logic curWrite_reg;
  logic [2:0] curSize_reg;
  logic [AD_W-1:0] curAddr_reg;
  logic [2:0] beat_reg;
  logic firstBeat_reg;
  logic agentFirst_reg;
  logic [AD_W-1:0] extAddr_reg;
  logic extIsWrite_reg;
  logic cancelReissue;
  logic lastBeat;
  logic issueRead;
  logic respCycle;
  logic respLast;
  logic readPending_reg;

  assign cancelReissue = firstBeat_reg && !wrAccept
                         && (writeStyle == bus_txn_pkg::WSTYLE_REISSUE);
  assign wbuf.outReady = (state_reg == ST_WDATA) && !cancelReissue;
  assign lastBeat = (beat_reg == beatsFor(curSize_reg) - 3'h1);
  assign issueRead = (state_reg == ST_WAITRDY) && !curWrite_reg && rdGo;
  // A data cycle inside an external write belongs to that write, not to a response.
  assign respCycle = extDataCycle && readPending_reg && (state_reg != ST_EXTDATA);
  assign respLast = respCycle && cmdIn[bus_txn_pkg::ID_LAST_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      ret_reg <= ST_IDLE;
      curWrite_reg <= 1'b0;
      curSize_reg <= bus_txn_pkg::SIZE_WORD;
      curAddr_reg <= '0;
      beat_reg <= 3'h0;
      firstBeat_reg <= 1'b0;
      agentFirst_reg <= 1'b0;
      extAddr_reg <= '0;
      extIsWrite_reg <= 1'b0;
      reqReady <= 1'b0;
      handoverN <= 1'b1;
      addr_data_bus_out <= '0;
      addr_data_bus_oe_n <= 1'b1;
      cmd_bus_out <= '0;
      cmd_bus_oe_n <= 1'b1;
      cpu_drive_valid_n <= 1'b1;
    end else begin
      reqReady <= 1'b0;
      handoverN <= 1'b1;
      addr_data_bus_oe_n <= 1'b1;
      cmd_bus_oe_n <= 1'b1;
      cpu_drive_valid_n <= 1'b1;
      case (state_reg)
        ST_IDLE: begin
          if (reqValid && reqReady) begin
            curWrite_reg <= reqWrite;
            curSize_reg <= reqSize;
            curAddr_reg <= reqAddr;
            agentFirst_reg <= agentReq;
            state_reg <= ST_WAITRDY;
          end else if (agentReq) begin
            handoverN <= 1'b0;
            agentFirst_reg <= 1'b0;
            ret_reg <= ST_IDLE;
            state_reg <= ST_SLAVE;
          end else begin
            reqReady <= 1'b1;
          end
          if (agentReq && agentFirst_reg) begin
            reqReady <= 1'b0;
          end
        end
        ST_WAITRDY: begin
          if (curWrite_reg ? (wrGo && wbuf.outValid && !readPending_reg) : rdGo) begin
            addr_data_bus_out <= curAddr_reg;
            addr_data_bus_oe_n <= 1'b0;
            cmd_bus_out <= {1'b0, curWrite_reg, 1'b0, 3'h0, curSize_reg};
            cmd_bus_oe_n <= 1'b0;
            cpu_drive_valid_n <= 1'b0;
            beat_reg <= 3'h0;
            firstBeat_reg <= curWrite_reg;
            state_reg <= curWrite_reg ? ST_WDATA : ST_RWAIT;
          end else if (agentReq && !(curWrite_reg ? wrAccept : rdAccept)) begin
            handoverN <= 1'b0;
            ret_reg <= ST_WAITRDY;
            state_reg <= ST_SLAVE;
          end
        end
        ST_WDATA: begin
          if (cancelReissue) begin
            state_reg <= ST_WAITRDY;
          end else if (wbuf.outValid) begin
            addr_data_bus_out <= wbuf.outData;
            addr_data_bus_oe_n <= 1'b0;
            cmd_bus_out <= {1'b1, lastBeat, 7'h00};
            cmd_bus_oe_n <= 1'b0;
            cpu_drive_valid_n <= 1'b0;
            firstBeat_reg <= 1'b0;
            beat_reg <= beat_reg + 3'h1;
            if (lastBeat) begin
              state_reg <= (writeStyle == bus_txn_pkg::WSTYLE_LEGACY) ? ST_WGAP : ST_IDLE;
            end
          end
        end
        ST_WGAP: begin
          state_reg <= ST_IDLE;
        end
        ST_RWAIT: begin
          if (!readPending_reg) begin
            state_reg <= ST_IDLE;
          end else if (agentReq && (!scEnable || scMiss)) begin
            handoverN <= 1'b0;
            ret_reg <= ST_RWAIT;
            state_reg <= ST_SLAVE;
          end
        end
        ST_SLAVE: begin
          if (extAddrCycle) begin
            if (cmdIn[bus_txn_pkg::CMD_NULL_BIT] || !cmdIn[bus_txn_pkg::CMD_WRITE_BIT]) begin
              state_reg <= afterSlave(ret_reg, readPending_reg);
            end else begin
              extAddr_reg <= adIn;
              extIsWrite_reg <= 1'b1;
              state_reg <= ST_EXTDATA;
            end
          end
        end
        ST_EXTDATA: begin
          // Further address cycles are ignored until the data word lands.
          if (extDataCycle) begin
            extIsWrite_reg <= 1'b0;
            state_reg <= afterSlave(ret_reg, readPending_reg);
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Read pending tracking.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readPending_reg <= 1'b0;
      readPending <= 1'b0;
    end else begin
      if (issueRead) begin
        readPending_reg <= 1'b1;
        readPending <= 1'b1;
      end else if (respLast) begin
        readPending_reg <= 1'b0;
        readPending <= 1'b0;
      end
    end
  end

  // Read response delivery, accepted in any state but ST_EXTDATA without arbitration.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdValid <= 1'b0;
      rdData <= '0;
      rdLast <= 1'b0;
      busError <= 1'b0;
    end else begin
      rdValid <= respCycle;
      rdLast <= respLast;
      busError <= respCycle && cmdIn[bus_txn_pkg::ID_ERROR_BIT];
      if (respCycle) begin
        rdData <= adIn;
      end
    end
  end

  // External writes reach only the interrupt register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intReg <= INT_WIDTH'(bus_txn_pkg::INT_REG_RESET);
    end else if ((state_reg == ST_EXTDATA) && extDataCycle && extIsWrite_reg
                 && (extAddr_reg == bus_txn_pkg::INT_REG_ADDR)) begin
      intReg <= adIn[INT_WIDTH-1:0];
    end
  end
endmodule // bus_txn_ctrl
`default_nettype wire

// ===== bus_txn_ctrl_asserts.sv
// Protocol checker for the bus transaction controller.
`timescale 1ns/1ps
`default_nettype none
module bus_txn_ctrl_asserts (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Core side.
  input wire logic readPending,
  input wire logic rdValid,
  input wire logic rdLast,
  input wire logic busError,
  // System bus pins.
  input wire logic [8:0] cmd_bus_out,
  input wire logic cmd_bus_oe_n,
  input wire logic addr_data_bus_oe_n,
  input wire logic cpu_drive_valid_n,
  input wire logic [8:0] cmd_bus_in,
  input wire logic agent_drive_valid_n,
  input wire logic read_accept_n,
  input wire logic write_accept_n,
  input wire logic agent_bus_request_n,
  input wire logic handoverN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic addrCyc;
  logic respCyc;
  logic extWin;
  assign addrCyc = !cpu_drive_valid_n && !cmd_bus_out[8];
  assign respCyc = !agent_drive_valid_n && cmd_bus_in[8] && readPending && !extWin;
  // An external write's data cycle is not a read response.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extWin <= 1'b0;
    end else if (!agent_drive_valid_n) begin
      extWin <= !cmd_bus_in[8] && cmd_bus_in[7];
    end
  end
  chk_handover_one_cycle: assert property ($fell(handoverN) |=> handoverN)
    else $error("handover held too long");
  chk_handover_cause: assert property (!handoverN |->
    !$past(agent_bus_request_n, 2) || !$past(agent_bus_request_n, 3))
    else $error("handover without request");
  chk_resp_to_core: assert property (respCyc |-> ##[1:4] rdValid)
    else $error("response word not passed on");
  chk_resp_error: assert property (respCyc && cmd_bus_in[6] |-> ##[1:4] busError)
    else $error("bus error missing");
  chk_pending_end: assert property ($fell(readPending) |-> ##[0:1] (rdLast || $past(rdLast)))
    else $error("read ended early");
  chk_valid_drives: assert property (!cpu_drive_valid_n |-> !cmd_bus_oe_n && !addr_data_bus_oe_n)
    else $error("valid without drive");
  chk_one_read: assert property (addrCyc && !cmd_bus_out[7] |-> !$past(readPending))
    else $error("second request issued");
  chk_write_no_read: assert property (addrCyc && cmd_bus_out[7] |-> !readPending)
    else $error("write during read");
  chk_read_gate: assert property (addrCyc && !cmd_bus_out[7] |-> !$past(read_accept_n, 3))
    else $error("read without ready");
  chk_write_gate: assert property (addrCyc && cmd_bus_out[7] |-> !$past(write_accept_n, 3))
    else $error("write without ready");
  cov_error_resp: cover property (respCyc && cmd_bus_in[6]);
  cov_split_grant: cover property (!handoverN && readPending);
  cov_write_issue: cover property (addrCyc && cmd_bus_out[7]);
endmodule // bus_txn_ctrl_asserts
bind bus_txn_ctrl bus_txn_ctrl_asserts u_chk (.clk, .rst_n, .readPending, .rdValid, .rdLast,
  .busError, .cmd_bus_out, .cmd_bus_oe_n, .addr_data_bus_oe_n, .cpu_drive_valid_n,
  .cmd_bus_in, .agent_drive_valid_n, .read_accept_n, .write_accept_n, .agent_bus_request_n,
  .handoverN);
`default_nettype wire

// ===== bus_agent_model.sv
// Behavioural external agent facing the processor bus.
`timescale 1ns/1ps
`default_nettype none
module bus_agent_model (
  // Clock.
  input wire logic clk,
  // Processor pins.
  input wire logic [8:0] cmd_bus_out,
  input wire logic cpu_drive_valid_n,
  input wire logic handoverN,
  // Agent pins.
  output logic [63:0] addr_data_bus_in,
  output logic [8:0] cmd_bus_in,
  output logic agent_drive_valid_n,
  output logic read_accept_n,
  output logic write_accept_n,
  output logic agent_bus_request_n
);
  logic [2:0] rdSize = 3'h0;
  initial begin
    addr_data_bus_in = 64'h0;
    cmd_bus_in = 9'h0;
    agent_drive_valid_n = 1'b1;
    read_accept_n = 1'b0;
    write_accept_n = 1'b0;
    agent_bus_request_n = 1'b1;
  end
  always @(negedge clk) begin
    if (cpu_drive_valid_n === 1'b0 && cmd_bus_out[8:7] === 2'h0) begin
      rdSize = cmd_bus_out[2:0];
    end
  end
  task automatic drive(input logic [8:0] c, input logic [63:0] d);
    @(negedge clk);
    agent_drive_valid_n = 1'b0;
    cmd_bus_in = c;
    addr_data_bus_in = d;
  endtask
  // A released bus shows the inverse of its last value.
  task automatic idle;
    @(negedge clk);
    agent_drive_valid_n = 1'b1;
    cmd_bus_in = ~cmd_bus_in;
    addr_data_bus_in = ~addr_data_bus_in;
  endtask
  // Sent without arbitration; the error mark rides on the first word.
  task automatic respond(input logic err);
    int n;
    n = (rdSize == bus_txn_pkg::SIZE_BLOCK) ? 4 : 1;
    for (int i = 0; i < n; i++) begin
      drive({1'b1, i == n - 1, err && i == 0, 6'h00}, 64'h1000 + 64'(i));
    end
    idle();
  endtask
  task automatic ext_req(input logic wr, input logic [63:0] a, input logic [63:0] d);
    int i;
    @(negedge clk);
    agent_bus_request_n = 1'b0;
    i = 0;
    while (handoverN !== 1'b0 && i < 40) begin
      @(posedge clk);
      #1;
      i++;
    end
    drive({1'b0, wr, !wr, 6'h00}, a);
    agent_bus_request_n = 1'b1;
    if (wr) begin
      drive(9'h100, d);
    end
    idle();
  endtask
endmodule // bus_agent_model
`default_nettype wire

// ===== system_bus_transaction_control_test.sv
// Self-checking bench for the bus transaction controller.
`timescale 1ns/1ps
`default_nettype none
module system_bus_transaction_control_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [2:0] reqSize = 3'h0;
  logic [63:0] reqAddr = 64'h0;
  logic wdValid = 1'b0;
  logic [63:0] wdData = 64'h0;
  logic [1:0] writeStyle = 2'h0;
  logic scEnable = 1'b0;
  logic scMiss = 1'b0;
  logic reqReady, wdReady, rdValid, rdLast, busError, readPending, handoverN;
  logic addr_data_bus_oe_n, cmd_bus_oe_n, cpu_drive_valid_n, agent_drive_valid_n;
  logic read_accept_n, write_accept_n, agent_bus_request_n;
  logic [63:0] rdData, addr_data_bus_in, addr_data_bus_out, lastRd, lastWr, lastAdr;
  logic [8:0] cmd_bus_in, cmd_bus_out, lastCmd;
  logic [7:0] intReg;
  int num_errors = 0;
  int checked = 0;
  int rdCnt = 0;
  int errCnt = 0;
  int hoCnt = 0;
  int wrBeats = 0;
  int lastCnt = 0;
  int adrCnt = 0;
  int base;
  int baseA;
  bus_txn_ctrl u_dut (.clk, .rst_n, .reqValid, .reqReady, .reqWrite, .reqSize, .reqAddr,
    .wdValid, .wdReady, .wdData, .rdValid, .rdData, .rdLast, .busError, .readPending,
    .writeStyle, .scEnable, .scMiss, .intReg, .addr_data_bus_in, .addr_data_bus_out,
    .addr_data_bus_oe_n, .cmd_bus_in, .cmd_bus_out, .cmd_bus_oe_n, .cpu_drive_valid_n,
    .agent_drive_valid_n, .read_accept_n, .write_accept_n, .agent_bus_request_n, .handoverN);
  bus_agent_model u_agent (.clk, .cmd_bus_out, .cpu_drive_valid_n, .handoverN,
    .addr_data_bus_in, .cmd_bus_in, .agent_drive_valid_n, .read_accept_n, .write_accept_n,
    .agent_bus_request_n);
  always #25 clk = ~clk;
  always @(negedge clk) begin
    if (rdValid === 1'b1) begin
      rdCnt++;
      lastRd = rdData;
    end
    if (rdLast === 1'b1) begin
      lastCnt++;
    end
    if (busError === 1'b1) begin
      errCnt++;
    end
    if (handoverN === 1'b0) begin
      hoCnt++;
    end
    if (cpu_drive_valid_n === 1'b0 && cmd_bus_out[8] === 1'b0) begin
      lastCmd = cmd_bus_out;
      lastAdr = addr_data_bus_out;
      adrCnt++;
    end else if (cpu_drive_valid_n === 1'b0) begin
      wrBeats++;
      lastWr = addr_data_bus_out;
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: %s got %h", $time, msg, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic issue(input logic wr, input logic [2:0] sz, input logic [63:0] a);
    int i;
    @(negedge clk);
    reqValid = 1'b1;
    reqWrite = wr;
    reqSize = sz;
    reqAddr = a;
    i = 0;
    while (reqReady !== 1'b1 && i < 200) begin
      @(negedge clk);
      i++;
    end
    @(negedge clk);
    reqValid = 1'b0;
    check(i < 200, 1'b1, "request refused");
  endtask
  task automatic wait_pend(input logic v);
    int i;
    i = 0;
    while (readPending !== v && i < 100) begin
      @(negedge clk);
      i++;
    end
    @(negedge clk);
    check(readPending, v, "read state");
  endtask
  task automatic push(input logic [63:0] d);
    @(negedge clk);
    wdValid = 1'b1;
    wdData = d;
    while (wdReady !== 1'b1) @(negedge clk);
    @(negedge clk);
    wdValid = 1'b0;
  endtask
  task automatic test_reads;
    for (int s = 0; s < 5; s++) begin
      base = rdCnt;
      issue(1'b0, 3'(s), 64'h100);
      wait_pend(1'b1);
      check(lastCmd, 9'(s), "read command");
      check(lastAdr, 64'h100, "read address");
      check(reqReady, 1'b0, "second request open");
      settle(3 * s);
      u_agent.respond(1'b0);
      wait_pend(1'b0);
      settle(3);
      check(rdCnt - base, (s == 4) ? 4 : 1, "response words");
      check(lastRd, (s == 4) ? 64'h1003 : 64'h1000, "response data");
      check(lastCnt, s + 1, "last word marks");
    end
    $display("test_reads done");
  endtask
  task automatic test_writes;
    for (int st = 0; st < 3; st++) begin
      writeStyle = 2'(st);
      u_agent.write_accept_n = 1'b1;
      base = wrBeats;
      baseA = adrCnt;
      for (int k = 0; k < 4; k++) push(64'ha0 + 64'(k));
      issue(1'b1, bus_txn_pkg::SIZE_BLOCK, 64'h200);
      settle(12);
      check(wrBeats - base, 0, "write without ready");
      // Three ready samples allow one issue; ready is gone again at the first data beat.
      u_agent.write_accept_n = 1'b0;
      settle(3);
      u_agent.write_accept_n = 1'b1;
      settle(12);
      check(wrBeats - base, (st == 1) ? 0 : 4, "reissue cut");
      u_agent.write_accept_n = 1'b0;
      settle(20);
      check(adrCnt - baseA, (st == 1) ? 2 : 1, "address cycles");
      check(lastAdr, 64'h200, "write address");
      check(lastCmd, 9'h084, "write command");
      check(wrBeats - base, 4, "write beats");
      check(lastWr, 64'ha3, "last write word");
    end
    $display("test_writes done");
  endtask
  task automatic test_read_gate;
    u_agent.read_accept_n = 1'b1;
    base = hoCnt;
    issue(1'b0, bus_txn_pkg::SIZE_DWORD, 64'h300);
    settle(10);
    check(readPending, 1'b0, "read without ready");
    u_agent.ext_req(1'b0, 64'h0, 64'h0);
    check(hoCnt - base, 1, "no grant while stalled");
    u_agent.read_accept_n = 1'b0;
    wait_pend(1'b1);
    u_agent.respond(1'b0);
    wait_pend(1'b0);
    $display("test_read_gate done");
  endtask
  task automatic test_split;
    scEnable = 1'b1;
    scMiss = 1'b1;
    issue(1'b0, bus_txn_pkg::SIZE_WORD, 64'h400);
    wait_pend(1'b1);
    u_agent.ext_req(1'b1, 64'h0, 64'h5a);
    settle(4);
    check(intReg, 8'h5a, "interrupt write");
    check(readPending, 1'b1, "split read lost");
    base = errCnt;
    u_agent.respond(1'b1);
    wait_pend(1'b0);
    settle(2);
    check(errCnt - base, 1, "bus error");
    u_agent.ext_req(1'b1, 64'h8, 64'ha5);
    u_agent.ext_req(1'b0, 64'h0, 64'h0);
    settle(4);
    check(intReg, 8'h5a, "interrupt changed");
    scMiss = 1'b0;
    issue(1'b0, bus_txn_pkg::SIZE_WORD, 64'h500);
    wait_pend(1'b1);
    base = hoCnt;
    u_agent.agent_bus_request_n = 1'b0;
    settle(8);
    u_agent.agent_bus_request_n = 1'b1;
    settle(2);
    check(hoCnt - base, 0, "handover before cache miss");
    u_agent.respond(1'b0);
    wait_pend(1'b0);
    $display("test_split done");
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    settle(16);
    rst_n = 1'b1;
    settle(4);
    check({handoverN, cpu_drive_valid_n, cmd_bus_oe_n, addr_data_bus_oe_n, intReg}, 12'hf00,
          "reset state");
    test_reads();
    test_writes();
    test_read_gate();
    test_split();
    final_report();
  end
  initial begin
    #500000;
    num_errors++;
    final_report();
  end
endmodule // system_bus_transaction_control_test
`default_nettype wire
